/* include/bcv_pkg.sv */
// Boot configuration vector capture: shared constants and types.
// Assumes one 20 MHz clock and an APB slave port with 32-bit data.
package bcv_pkg;

  // ==========================================================
  // Configuration word layout
  typedef struct packed {
    logic [1:0] rsv_hi;
    logic       tx_ind_en;
    logic       bscan_rst_en;
    logic       sysclk_off;
    logic       dma_dbg_en;
    logic       short_warm;
    logic       ice_en;
    logic [1:0] boot_width;
    logic       debug_boot;
    logic       rsv_lo;
    logic       big_endian;
    logic [2:0] clk_mult;
  } bcv_cfg_t;

  localparam int CFG_W = 16;
  localparam logic [15:0] CFG_RESET = 16'h0000;

  // Multiplier and width codes
  localparam logic [2:0] MULT_X2 = 3'h0;
  localparam logic [2:0] MULT_X3 = 3'h1;
  localparam logic [2:0] MULT_X4 = 3'h2;
  localparam logic [2:0] FACTOR_X2 = 3'h2;
  localparam logic [2:0] FACTOR_X3 = 3'h3;
  localparam logic [2:0] FACTOR_X4 = 3'h4;
  localparam logic [1:0] WIDTH_RSV = 2'h3;

  // ==========================================================
  // Warm reset pulse lengths in clock cycles
  localparam int WARM_LONG_CYC = 4096;
  localparam int WARM_SHORT_CYC = 64;
  localparam int WCNT_W = 13;
  localparam logic [WCNT_W-1:0] WARM_LONG_LEN = WCNT_W'(WARM_LONG_CYC);
  localparam logic [WCNT_W-1:0] WARM_SHORT_LEN = WCNT_W'(WARM_SHORT_CYC);

  // ==========================================================
  // General pin positions of alternate functions
  localparam int PIN_DBG_RST = 31;
  localparam int PIN_TRACE_CLK = 13;
  localparam int PIN_PCST0 = 10;
  localparam int PIN_DMA3 = 8;
  localparam int PIN_DMA2 = 9;
  localparam int PIN_DMA1 = 25;
  localparam int PIN_DMA0 = 23;
  localparam int PIN_TAP_RST = 2;
  localparam int PIN_CPU_IND = 4;

  // ==========================================================
  // APB register map (byte addresses)
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] REG_CFG = 12'h000;
  localparam logic [ADDR_W-1:0] REG_STATUS = 12'h004;
  localparam logic [ADDR_W-1:0] REG_CTRL = 12'h008;

  // Status bits
  localparam int ST_CFG_VALID = 0;
  localparam int ST_WARM_ACTIVE = 1;
  localparam int ST_RSV_VIOL = 2;
  localparam int ST_WARM_LINE = 3;
  localparam int ST_COLD = 4;

  // Control bits
  localparam int CT_WARM_GO = 0;

endpackage

/* rtl/bcv_capture.sv */
// Boot configuration capture, applied settings, pin overlay and warm reset.
// Assumes all inputs synchronous to I_MCLK and a zero-wait APB master.
`timescale 1ns/10ps

// Overview of operation
// - The configuration word is taken from the memory data bus only while cold reset is active.
// - The captured settings take effect when cold reset ends and then stay fixed.
// - Bits 2:0 pick the core clock multiplier x2, x3 or x4; codes 3 to 7 are reserved.
// - Bit 3 selects little endian at zero and big endian at one.
// - Bit 5 selects regular start-up at zero and debug boot at one.
// - Bits 7:6 give boot width 8, 16 or 32 bits; code 3 is reserved.
// - Bit 8 turns pin 31 into debug port reset and pins 12:10 into trace status.
// - Bit 9 shortens the warm reset pulse from 4096 to 64 clock cycles.
// - Bit 10 makes pins 8, 9, 25 and 23 report DMA activity.
// - Bit 11 holds the system clock output at a constant level.
// - Bit 12 turns pin 2 into the test access port reset input.
// - Bit 13 makes pin 4 carry the CPU versus DMA transaction indicator.
// - With the debug interface on, pin 13 carries the trace clock.
// - With DMA debug on, pin 8 carries DMA status 3 and pin 9 DMA status 2.
module bcv_capture
  import bcv_pkg::*;
(
  // Clock and reset
  input wire logic I_MCLK,
  input wire logic I_WARM_RESET_LINE,
  input wire logic I_COLD_WARM_RESET_LINE,
  // Boot word source
  input wire logic [15:0] I_MEMORY_DATA_BUS,
  // APB slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [ADDR_W-1:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // Warm reset line, open drain
  input wire logic I_WARM_RESET_LINE_I,
  output logic O_WARM_RESET_LINE_O,
  output logic O_WARM_RESET_LINE_OE,
  input wire logic I_WARM_REQ,
  // System clock output
  output logic O_SYSTEM_CLOCK_OUT,
  // Applied settings
  output logic O_CFG_VALID,
  output logic [2:0] O_CLK_MULT_CODE,
  output logic [2:0] O_CLK_FACTOR,
  output logic O_BIG_ENDIAN,
  output logic O_DEBUG_BOOT,
  output logic [1:0] O_BOOT_WIDTH,
  // Alternate function sources
  input wire logic [2:0] I_PC_TRACE_STATUS,
  input wire logic I_PC_TRACE_CLOCK,
  input wire logic [3:0] I_DMA_STATUS_PINS,
  input wire logic I_CPU_DMA_INDICATOR,
  // General pins
  input wire logic [31:0] I_GPIO_OUT,
  input wire logic [31:0] I_GPIO_OE,
  input wire logic [31:0] I_GENERAL_IO_PINS_I,
  output logic [31:0] O_GENERAL_IO_PINS_O,
  output logic [31:0] O_GENERAL_IO_PINS_OE,
  output logic O_DEBUG_PORT_RESET_N,
  output logic O_TAP_RESET_N
);

  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (!I_WARM_RESET_LINE);

  // ==========================================================
  // Cold reset tracking and capture
  logic cold_active;
  logic cold_d_reg;
  logic cold_end;
  bcv_cfg_t cap_reg;
  bcv_cfg_t cfg_reg;
  logic cfg_valid_reg;
  logic rsv_viol_reg;
  logic rsv_viol_next;

  assign cold_active = !I_COLD_WARM_RESET_LINE;
  assign cold_end = cold_d_reg && !cold_active;

  always_ff @(posedge I_MCLK) begin
    if (!I_WARM_RESET_LINE) begin
      cold_d_reg <= 1'b0;
      cap_reg <= bcv_cfg_t'(CFG_RESET);
    end else begin
      cold_d_reg <= cold_active;
      if (cold_active) begin
        cap_reg <= bcv_cfg_t'(I_MEMORY_DATA_BUS);
      end
    end
  end

  // Reserved fields flagged for software
  assign rsv_viol_next = (cap_reg.rsv_hi != 2'h0) || cap_reg.rsv_lo
    || (cap_reg.clk_mult > MULT_X4) || (cap_reg.boot_width == WIDTH_RSV);

  always_ff @(posedge I_MCLK) begin
    if (!I_WARM_RESET_LINE) begin
      cfg_reg <= bcv_cfg_t'(CFG_RESET);
      cfg_valid_reg <= 1'b0;
      rsv_viol_reg <= 1'b0;
    end else if (cold_end) begin
      cfg_reg <= cap_reg;
      cfg_valid_reg <= 1'b1;
      rsv_viol_reg <= rsv_viol_next;
    end else if (cold_active) begin
      cfg_valid_reg <= 1'b0;
    end
  end

  capture_only_cold_a: assert property (!cold_active |=> $stable(cap_reg))
    else $error("capture changed outside cold reset");
  apply_at_end_a: assert property (cold_end |=> cfg_reg == $past(cap_reg))
    else $error("settings not applied at cold reset end");
  settings_hold_a: assert property (cfg_valid_reg && !cold_active |=> $stable(cfg_reg))
    else $error("applied settings changed after cold reset");

  // ==========================================================
  // Decoded settings
  logic [2:0] factor;

  assign factor = (cfg_reg.clk_mult == MULT_X2) ? FACTOR_X2 :
    (cfg_reg.clk_mult == MULT_X3) ? FACTOR_X3 :
    (cfg_reg.clk_mult == MULT_X4) ? FACTOR_X4 : FACTOR_X2;

  assign O_CFG_VALID = cfg_valid_reg;
  assign O_CLK_MULT_CODE = cfg_reg.clk_mult;
  assign O_CLK_FACTOR = factor;
  assign O_BIG_ENDIAN = cfg_reg.big_endian;
  assign O_DEBUG_BOOT = cfg_reg.debug_boot;
  assign O_BOOT_WIDTH = cfg_reg.boot_width;

  mult_factor_a: assert property (
    cfg_valid_reg && cfg_reg.clk_mult == 3'h1 |-> O_CLK_FACTOR == 3'h3)
    else $error("multiplier code 1 not decoded to x3");
  endian_follow_a: assert property (
    cold_end ##1 1'b1 |-> O_BIG_ENDIAN == $past(cap_reg.big_endian))
    else $error("endian output does not follow captured bit");
  boot_width_a: assert property (
    cold_end |=> O_BOOT_WIDTH == $past(I_MEMORY_DATA_BUS[7:6], 2))
    else $error("boot width does not follow captured field");
  mult_x2_a: assert property (
    cfg_valid_reg && cfg_reg.clk_mult == 3'h0 |-> O_CLK_FACTOR == 3'h2)
    else $error("multiplier code 0 not decoded to x2");
  mult_x4_a: assert property (
    cfg_valid_reg && cfg_reg.clk_mult == 3'h2 |-> O_CLK_FACTOR == 3'h4)
    else $error("multiplier code 2 not decoded to x4");
  debug_boot_a: assert property (
    cold_end |=> O_DEBUG_BOOT == $past(cap_reg.debug_boot))
    else $error("boot mode does not follow captured bit");

  // ==========================================================
  // System clock output, half of I_MCLK unless held
  logic sysclk_reg;

  always_ff @(posedge I_MCLK) begin
    if (!I_WARM_RESET_LINE) begin
      sysclk_reg <= 1'b0;
    end else if (cfg_reg.sysclk_off) begin
      sysclk_reg <= 1'b0;
    end else begin
      sysclk_reg <= !sysclk_reg;
    end
  end

  assign O_SYSTEM_CLOCK_OUT = sysclk_reg;

  sysclk_quiet_a: assert property (cfg_reg.sysclk_off |=> !O_SYSTEM_CLOCK_OUT)
    else $error("system clock output toggles while disabled");

  // ==========================================================
  // Warm reset pulse
  logic warm_active_reg;
  logic [WCNT_W-1:0] warm_cnt_reg;
  logic [WCNT_W-1:0] warm_len;
  logic warm_start;
  logic sw_warm_go;

  // Short pulse only when the board strapped the test bit
  assign warm_len = cfg_reg.short_warm ? WARM_SHORT_LEN : WARM_LONG_LEN;
  assign warm_start = (I_WARM_REQ || sw_warm_go) && !warm_active_reg
    && cfg_valid_reg && !cold_active;

  always_ff @(posedge I_MCLK) begin
    if (!I_WARM_RESET_LINE) begin
      warm_active_reg <= 1'b0;
      warm_cnt_reg <= '0;
    end else if (warm_start) begin
      warm_active_reg <= 1'b1;
      warm_cnt_reg <= warm_len - WCNT_W'(1);
    end else if (warm_active_reg) begin
      if (warm_cnt_reg == '0) begin
        warm_active_reg <= 1'b0;
      end
      warm_cnt_reg <= warm_cnt_reg - WCNT_W'(1);
    end
  end

  assign O_WARM_RESET_LINE_O = 1'b0;
  assign O_WARM_RESET_LINE_OE = warm_active_reg;

  // Helper: length of the pulse just driven
  logic [WCNT_W-1:0] pulse_len_reg;

  always_ff @(posedge I_MCLK) begin
    if (!I_WARM_RESET_LINE || !warm_active_reg) begin
      pulse_len_reg <= '0;
    end else begin
      pulse_len_reg <= pulse_len_reg + WCNT_W'(1);
    end
  end

  warm_length_a: assert property (
    $fell(warm_active_reg) |-> pulse_len_reg == warm_len)
    else $error("warm reset pulse has the wrong length");

  // ==========================================================
  // General pin overlay
  logic [31:0] alt_sel;
  logic [31:0] alt_o;
  logic [31:0] alt_oe;
  logic [31:0] pin_o_reg;
  logic [31:0] pin_oe_reg;
  logic dbg_rst_n_reg;
  logic tap_rst_n_reg;

  always_comb begin
    alt_sel = '0;
    alt_o = '0;
    alt_oe = '0;
    if (cfg_reg.ice_en) begin
      alt_sel[PIN_DBG_RST] = 1'b1;
      alt_sel[PIN_PCST0 +: 3] = 3'h7;
      alt_o[PIN_PCST0 +: 3] = I_PC_TRACE_STATUS;
      alt_oe[PIN_PCST0 +: 3] = 3'h7;
      alt_sel[PIN_TRACE_CLK] = 1'b1;
      alt_o[PIN_TRACE_CLK] = I_PC_TRACE_CLOCK;
      alt_oe[PIN_TRACE_CLK] = 1'b1;
    end
    if (cfg_reg.dma_dbg_en) begin
      alt_sel[PIN_DMA3] = 1'b1;
      alt_o[PIN_DMA3] = I_DMA_STATUS_PINS[3];
      alt_oe[PIN_DMA3] = 1'b1;
      alt_sel[PIN_DMA2] = 1'b1;
      alt_o[PIN_DMA2] = I_DMA_STATUS_PINS[2];
      alt_oe[PIN_DMA2] = 1'b1;
      alt_sel[PIN_DMA1] = 1'b1;
      alt_o[PIN_DMA1] = I_DMA_STATUS_PINS[1];
      alt_oe[PIN_DMA1] = 1'b1;
      alt_sel[PIN_DMA0] = 1'b1;
      alt_o[PIN_DMA0] = I_DMA_STATUS_PINS[0];
      alt_oe[PIN_DMA0] = 1'b1;
    end
    if (cfg_reg.bscan_rst_en) begin
      alt_sel[PIN_TAP_RST] = 1'b1;
    end
    if (cfg_reg.tx_ind_en) begin
      alt_sel[PIN_CPU_IND] = 1'b1;
      alt_o[PIN_CPU_IND] = I_CPU_DMA_INDICATOR;
      alt_oe[PIN_CPU_IND] = 1'b1;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_WARM_RESET_LINE) begin
      pin_o_reg <= '0;
      pin_oe_reg <= '0;
      dbg_rst_n_reg <= 1'b0;
      tap_rst_n_reg <= 1'b0;
    end else begin
      pin_o_reg <= (alt_sel & alt_o) | (~alt_sel & I_GPIO_OUT);
      pin_oe_reg <= (alt_sel & alt_oe) | (~alt_sel & I_GPIO_OE);
      dbg_rst_n_reg <= !cfg_reg.ice_en || I_GENERAL_IO_PINS_I[PIN_DBG_RST];
      tap_rst_n_reg <= !cfg_reg.bscan_rst_en || I_GENERAL_IO_PINS_I[PIN_TAP_RST];
    end
  end

  assign O_GENERAL_IO_PINS_O = pin_o_reg;
  assign O_GENERAL_IO_PINS_OE = pin_oe_reg;
  assign O_DEBUG_PORT_RESET_N = dbg_rst_n_reg;
  assign O_TAP_RESET_N = tap_rst_n_reg;

  trace_status_a: assert property (
    cfg_reg.ice_en && $stable(cfg_reg)
      |=> O_GENERAL_IO_PINS_O[12:10] == $past(I_PC_TRACE_STATUS) && O_GENERAL_IO_PINS_OE[12])
    else $error("trace status not routed to pins 12 to 10");
  dma_status_a: assert property (
    cfg_reg.dma_dbg_en && $stable(cfg_reg)
      |=> O_GENERAL_IO_PINS_O[8] == $past(I_DMA_STATUS_PINS[3])
        && O_GENERAL_IO_PINS_O[9] == $past(I_DMA_STATUS_PINS[2]))
    else $error("DMA status not routed to pins 8 and 9");
  cpu_ind_a: assert property (
    !cfg_reg.tx_ind_en && $stable(cfg_reg)
      |=> O_GENERAL_IO_PINS_O[4] == $past(I_GPIO_OUT[4]))
    else $error("pin 4 not general purpose while indicator off");
  tap_reset_a: assert property (
    !cfg_reg.bscan_rst_en && $stable(cfg_reg) |=> O_TAP_RESET_N)
    else $error("tap reset asserted while disabled");
  debug_reset_a: assert property (
    cfg_reg.ice_en && $stable(cfg_reg)
      |=> O_DEBUG_PORT_RESET_N == $past(I_GENERAL_IO_PINS_I[PIN_DBG_RST])
        && !O_GENERAL_IO_PINS_OE[PIN_DBG_RST])
    else $error("debug port reset not taken from pin 31");
  trace_clock_a: assert property (
    cfg_reg.ice_en && $stable(cfg_reg)
      |=> O_GENERAL_IO_PINS_O[PIN_TRACE_CLK] == $past(I_PC_TRACE_CLOCK)
        && O_GENERAL_IO_PINS_OE[PIN_TRACE_CLK])
    else $error("trace clock not routed to pin 13");

  // ==========================================================
  // APB slave, zero wait states
  logic setup_ph;
  logic access_ph;
  logic hit_cfg;
  logic hit_status;
  logic hit_ctrl;
  logic addr_ok;
  logic [31:0] rd_mux;
  logic [31:0] status_word;
  logic [31:0] prdata_reg;

  assign setup_ph = I_PSEL && !I_PENABLE;
  assign access_ph = I_PSEL && I_PENABLE;
  assign hit_cfg = (I_PADDR == REG_CFG);
  assign hit_status = (I_PADDR == REG_STATUS);
  assign hit_ctrl = (I_PADDR == REG_CTRL);
  assign addr_ok = hit_cfg || hit_status || hit_ctrl;

  assign status_word = {27'h0, cold_active, I_WARM_RESET_LINE_I, rsv_viol_reg,
    warm_active_reg, cfg_valid_reg};
  assign rd_mux = hit_cfg ? {16'h0, cfg_reg} :
    hit_status ? status_word : 32'h0;

  assign sw_warm_go = access_ph && I_PWRITE && hit_ctrl && I_PWDATA[CT_WARM_GO];

  always_ff @(posedge I_MCLK) begin
    if (!I_WARM_RESET_LINE) begin
      prdata_reg <= '0;
    end else if (setup_ph) begin
      prdata_reg <= I_PWRITE ? 32'h0 : rd_mux;
    end
  end

  assign O_PRDATA = prdata_reg;
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = access_ph && !addr_ok;

endmodule

/* tb/bcv_board_model.sv */
// Board strapping model that drives the boot word on the memory data bus.
// Assumes the bench supplies the word and the cold reset level.
`timescale 1ns/10ps
module bcv_board_model
  import bcv_pkg::*;
(
  // Clock and cold reset
  input wire logic i_clk,
  input wire logic i_cold_warm_reset_line,
  // Word to present
  input wire logic [15:0] i_word,
  // Memory data bus
  output logic [15:0] o_bus
);
  // ==========================================================
  // Strap drive
  logic [15:0] strap;
  logic [15:0] float_reg;
  always_comb begin
    strap = i_word & 16'h3fef;
    if (strap[2:0] > 3'h2) strap[2:0] = 3'h0;
    if (strap[7:6] == 2'h3) strap[7:6] = 2'h0;
  end
  // Released bus changes every cycle
  always_ff @(posedge i_clk) begin
    float_reg <= ~o_bus;
  end
  // Short pulse bit set only on test runs
  assign o_bus = i_cold_warm_reset_line ? float_reg : strap;
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the boot configuration capture block.
// Assumes a pull-up on the warm reset line and the board model on the data bus.
`timescale 1ns/10ps
module tb_top
  import bcv_pkg::*;
;
  logic clk = 0, warm_reset_line = 0, cold_n = 0, psel = 0, pen = 0, pwr = 0, wreq = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, go = 0, goe = 0, pads = 0, po, poe;
  logic [15:0] word = 0, bus;
  logic [2:0] pcst = 0, mc, fac;
  logic tclk = 0, cpu = 0, ready, err, wo, woe, sclk, vld, be, db, dbr, tapr;
  logic [3:0] dma = 0;
  logic [1:0] bw;
  wire wline = woe ? wo : 1'b1;
  int mismatches = 0, checked = 0, seed = 13659, n;
  logic [31:0] rd, eo, eoe, care;
  logic e;
  always #25 clk = ~clk;
  bcv_board_model board (.i_clk(clk), .i_cold_warm_reset_line(cold_n), .i_word(word), .o_bus(bus));
  bcv_capture dut (.I_MCLK(clk), .I_WARM_RESET_LINE(warm_reset_line), .I_COLD_WARM_RESET_LINE(cold_n),
    .I_MEMORY_DATA_BUS(bus), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(ready),
    .O_PSLVERR(err), .I_WARM_RESET_LINE_I(wline), .O_WARM_RESET_LINE_O(wo),
    .O_WARM_RESET_LINE_OE(woe), .I_WARM_REQ(wreq), .O_SYSTEM_CLOCK_OUT(sclk),
    .O_CFG_VALID(vld), .O_CLK_MULT_CODE(mc), .O_CLK_FACTOR(fac), .O_BIG_ENDIAN(be),
    .O_DEBUG_BOOT(db), .O_BOOT_WIDTH(bw), .I_PC_TRACE_STATUS(pcst),
    .I_PC_TRACE_CLOCK(tclk), .I_DMA_STATUS_PINS(dma), .I_CPU_DMA_INDICATOR(cpu),
    .I_GPIO_OUT(go), .I_GPIO_OE(goe), .I_GENERAL_IO_PINS_I(pads),
    .O_GENERAL_IO_PINS_O(po), .O_GENERAL_IO_PINS_OE(poe),
    .O_DEBUG_PORT_RESET_N(dbr), .O_TAP_RESET_N(tapr));
  // ==========================================================
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (ready !== 1'b1);
    rd = prdata;
    e = err;
    psel <= 0; pen <= 0;
  endtask
  task automatic settings();
    chk({vld, be, db, bw, mc, fac}, {1'b1, word[3], word[5], word[7:6], word[2:0],
      word[2:0] + 3'h2});
  endtask
  task automatic complete_run();
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    complete_run();
  end
  // ==========================================================
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    warm_reset_line <= 1;
    for (int i = 0; i < 4; i++) begin
      word <= ($random(seed) & 16'h0028) | 16'(i % 3) | 16'(((i + 1) % 3) << 6) |
        (i[0] ? 16'h3f00 : 16'h0000);
      cold_n <= 0;
      repeat (3) @(posedge clk);
      chk(vld, 0);
      apb(0, REG_STATUS, 0);
      chk(rd, 32'h18);
      cold_n <= 1;
      {go, goe, pads} <= {$random(seed), $random(seed), $random(seed)};
      {pcst, tclk, dma, cpu} <= 9'($random(seed));
      repeat (3) @(posedge clk);
      settings();
      eo = go; eoe = goe; care = '1;
      if (word[8]) begin
        eo[13:10] = {tclk, pcst}; eoe[13:10] = 4'hf; eoe[31] = 0; care[31] = 0;
      end
      if (word[10]) begin
        {eo[8], eo[9], eo[25], eo[23]} = dma; {eoe[8], eoe[9], eoe[25], eoe[23]} = 4'hf;
      end
      if (word[12]) begin
        eoe[2] = 0; care[2] = 0;
      end
      if (word[13]) begin
        eo[4] = cpu; eoe[4] = 1;
      end
      chk(po & care, eo & care);
      chk(poe, eoe);
      chk({dbr, tapr}, {word[8] ? pads[31] : 1'b1, word[12] ? pads[2] : 1'b1});
      for (int k = 0; k < 4; k++) begin
        e = sclk;
        @(posedge clk);
        chk(sclk, word[11] ? 1'b0 : !e);
      end
      apb(0, REG_CFG, 0);
      chk(rd, {16'h0, word});
      apb(0, REG_STATUS, 0);
      chk(rd, 32'h9);
      apb(0, 12'h00c, 0);
      chk(rd, 32'h0);
      chk(e, 1'b1);
      if (i[0]) apb(1, REG_CTRL, 1);
      else begin
        wreq <= 1;
        @(posedge clk);
        wreq <= 0;
      end
      n = 0;
      while (woe !== 1'b1 && n < 8) begin
        @(posedge clk);
        n++;
      end
      chk({woe, wo, wline}, 3'h4);
      n = 0;
      while (woe === 1'b1 && n < 5000) begin
        @(posedge clk);
        n++;
      end
      chk(n, word[9] ? WARM_SHORT_CYC : WARM_LONG_CYC);
      settings();
    end
    complete_run();
  end
endmodule
